// file: design/tlc_loop_code.sv
// T1 in-band loop code generator and three loop code detectors
//
// Our own choice: the APB interface to the registers.
`include "tlc_consts.svh"

module tlc_loop_code #(
   parameter int unsigned INTEG_BITS = `TLC_INTEG_BITS
)
(
   // Clock and reset
   input wire logic ref_clk,
   input wire logic srst,
   // APB slave
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire tlc_pkg::tlc_addr_t paddr,
   input wire tlc_pkg::tlc_data_t pwdata,
   output tlc_pkg::tlc_data_t prdata,
   output logic pready,
   output logic pslverr,
   // Framer configuration
   input wire logic t1_mode,
   input wire logic [2:0] framer_num,
   // Transmit bit stream
   input wire logic tx_bit_req,
   input wire logic tx_fbit_pos,
   input wire logic tx_fbit,
   output logic tx_loop_active,
   output logic tx_loop_data,
   // Receive bit stream
   input wire logic rx_bit_valid,
   input wire logic rx_bit,
   input wire logic rx_fbit_pos,
   // Status toward framer interrupt logic
   output logic loop_irq_pending
);
   import tlc_pkg::*;

   localparam logic [16:0] WIN_LAST = 17'(INTEG_BITS - 1);
   localparam logic [16:0] ERR_LIMIT = 17'(INTEG_BITS / `TLC_ERR_DIV);

   logic [7:0] rx_len_ctrl_reg;
   logic [7:0] rx_spare_ctrl_reg;
   logic [7:0] rx_irq_mask_reg;
   logic [7:0] tx_ctrl3_reg;
   logic [7:0] tx_ctrl4_reg;
   logic [7:0] tx_def1_reg;
   logic [7:0] tx_def2_reg;
   logic [7:0] rx_def1_reg [3];
   logic [7:0] rx_def2_reg [3];
   logic [5:0] latched_reg;
   logic [2:0] framer_reg;
   logic live_reg [3];
   logic live_d_reg [3];
   logic restart [3];
   logic win_end [3];
   logic [2:0] live_vec;
   logic [2:0] rise_vec;
   logic [2:0] fall_vec;
   logic [8:0] idx;
   logic hit;
   logic wr_en;
   logic setup;
   logic [7:0] rd_byte;

   // Strap caught while reset is held
   always_ff @(posedge ref_clk)
   begin
      if (srst)
         framer_reg <= framer_num;
   end

   // Bus decode
   assign idx = paddr[`TLC_ADDR_IDX_HI:`TLC_ADDR_IDX_LO];
   assign setup = psel & ~penable;
   assign wr_en = psel & penable & pready & pwrite;

   always_comb
   begin
      hit = 1'b1;
      rd_byte = `TLC_RST_BYTE;
      unique case (idx)
         `TLC_IDX_RX_LEN_CTRL: rd_byte = rx_len_ctrl_reg;
         `TLC_IDX_RX_LATCHED: rd_byte = {2'b00, latched_reg};
         `TLC_IDX_RX_SPARE_DEF1: rd_byte = rx_def1_reg[2];
         `TLC_IDX_RX_SPARE_DEF2: rd_byte = rx_def2_reg[2];
         `TLC_IDX_RX_SPARE_CTRL: rd_byte = rx_spare_ctrl_reg;
         `TLC_IDX_RX_IRQ_MASK: rd_byte = rx_irq_mask_reg;
         `TLC_IDX_RX_UP_DEF1: rd_byte = rx_def1_reg[0];
         `TLC_IDX_RX_UP_DEF2: rd_byte = rx_def2_reg[0];
         `TLC_IDX_RX_DOWN_DEF1: rd_byte = rx_def1_reg[1];
         `TLC_IDX_RX_DOWN_DEF2: rd_byte = rx_def2_reg[1];
         `TLC_IDX_RX_LIVE: rd_byte = {5'b00000, live_vec};
         `TLC_IDX_TX_CTRL3: rd_byte = tx_ctrl3_reg;
         `TLC_IDX_TX_CTRL4: rd_byte = tx_ctrl4_reg;
         `TLC_IDX_TX_DEF1: rd_byte = tx_def1_reg;
         `TLC_IDX_TX_DEF2: rd_byte = tx_def2_reg;
         default: hit = 1'b0;
      endcase
      if (paddr[`TLC_ADDR_FRAMER_HI:`TLC_ADDR_FRAMER_LO] != framer_reg)
         hit = 1'b0;
   end

   // Zero-wait answer: data captured in setup, ready in access
   always_ff @(posedge ref_clk)
   begin
      if (srst)
      begin
         pready <= 1'b0;
         pslverr <= 1'b0;
         prdata <= 32'h0000_0000;
      end
      else
      begin
         pready <= setup;
         pslverr <= setup & ~hit;
         prdata <= (setup & hit & ~pwrite) ? {24'h00_0000, rd_byte} : 32'h0000_0000;
      end
   end

   // Control and definition registers
   always_ff @(posedge ref_clk)
   begin
      if (srst)
      begin
         rx_len_ctrl_reg <= `TLC_RST_BYTE;
         rx_spare_ctrl_reg <= `TLC_RST_BYTE;
         rx_irq_mask_reg <= `TLC_RST_BYTE;
         tx_ctrl3_reg <= `TLC_RST_BYTE;
         tx_ctrl4_reg <= `TLC_RST_BYTE;
         tx_def1_reg <= `TLC_RST_BYTE;
         tx_def2_reg <= `TLC_RST_BYTE;
      end
      else if (wr_en & hit)
      begin
         unique case (idx)
            `TLC_IDX_RX_LEN_CTRL: rx_len_ctrl_reg <= pwdata[7:0];
            `TLC_IDX_RX_SPARE_CTRL: rx_spare_ctrl_reg <= pwdata[7:0];
            `TLC_IDX_RX_IRQ_MASK: rx_irq_mask_reg <= pwdata[7:0];
            `TLC_IDX_TX_CTRL3: tx_ctrl3_reg <= pwdata[7:0];
            `TLC_IDX_TX_CTRL4: tx_ctrl4_reg <= pwdata[7:0];
            `TLC_IDX_TX_DEF1: tx_def1_reg <= pwdata[7:0];
            `TLC_IDX_TX_DEF2: tx_def2_reg <= pwdata[7:0];
            default: ;
         endcase
      end
   end

   // Transmit generator
   logic tx_on;
   logic fbit_off;
   tlc_tx_len_e tx_len;
   tlc_phase_t tx_phase_reg;
   tlc_phase_t tx_last;
   logic [15:0] tx_pat;

   assign tx_on = t1_mode & tx_ctrl3_reg[`TLC_TX3_LOOP_EN];
   assign fbit_off = tx_ctrl3_reg[`TLC_TX3_FBIT_OFF];
   assign tx_len = tlc_tx_len_e'(tx_ctrl4_reg[`TLC_TX4_LEN_HI:`TLC_TX4_LEN_LO]);
   // Short lengths repeat the first byte; 16 joins both bytes
   assign tx_pat = (tx_len == TLC_TX_LEN16) ? {tx_def1_reg, tx_def2_reg}
                                            : {tx_def1_reg, tx_def1_reg};

   always_comb
   begin
      unique case (tx_len)
         TLC_TX_LEN5: tx_last = 4'h4;
         TLC_TX_LEN6: tx_last = 4'h5;
         TLC_TX_LEN7: tx_last = 4'h6;
         TLC_TX_LEN16: tx_last = `TLC_LAST16;
      endcase
   end

   always_ff @(posedge ref_clk)
   begin
      if (srst | ~tx_on)
         tx_phase_reg <= `TLC_RST_PHASE;
      else if (tx_bit_req)
         tx_phase_reg <= (tx_phase_reg >= tx_last) ? `TLC_RST_PHASE : tx_phase_reg + 4'h1;
   end

   always_ff @(posedge ref_clk)
   begin
      if (srst)
      begin
         tx_loop_active <= 1'b0;
         tx_loop_data <= 1'b0;
      end
      else
      begin
         tx_loop_active <= tx_on;
         if (tx_on & tx_bit_req)
            tx_loop_data <= (tx_fbit_pos & ~fbit_off) ? tx_fbit
                                                      : tx_pat[4'hF - tx_phase_reg];
      end
   end

   // Receive detectors: 0 up, 1 down, 2 spare
   genvar gi;
   generate
      for (gi = 0; gi < 3; gi++)
      begin : g_det
         logic [3:0] len_field;
         tlc_phase_t last;
         tlc_phase_t phase_reg;
         logic [3:0] slip_reg;
         logic [16:0] bit_cnt_reg;
         logic [16:0] err_cnt_reg;
         logic [15:0] pat;
         logic cmp;
         logic miss;
         logic slip;

         assign len_field = (gi == 0) ? rx_len_ctrl_reg[`TLC_LEN_UP_HI:`TLC_LEN_UP_LO]
                          : (gi == 1) ? rx_len_ctrl_reg[`TLC_LEN_DN_HI:`TLC_LEN_DN_LO]
                          : rx_spare_ctrl_reg[`TLC_LEN_UP_HI:`TLC_LEN_UP_LO];
         // Codes 0..7 give lengths 1..8, anything higher gives 16
         assign last = len_field[3] ? `TLC_LAST16 : {1'b0, len_field[2:0]};
         assign pat = len_field[3] ? {rx_def1_reg[gi], rx_def2_reg[gi]}
                                   : {rx_def1_reg[gi], rx_def1_reg[gi]};
         // F-bit slot skipped so inserted and overwritten framing both fit
         assign cmp = rx_bit_valid & ~rx_fbit_pos & t1_mode;
         assign miss = cmp & (rx_bit != pat[4'hF - phase_reg]);
         assign slip = miss & (slip_reg + `TLC_SLIP_UP >= `TLC_SLIP_LIMIT);
         assign win_end[gi] = cmp & (bit_cnt_reg == WIN_LAST);
         assign restart[gi] = wr_en & hit & (gi == 0 ? (idx == `TLC_IDX_RX_UP_DEF1 ||
                              idx == `TLC_IDX_RX_UP_DEF2) : gi == 1 ?
                              (idx == `TLC_IDX_RX_DOWN_DEF1 || idx == `TLC_IDX_RX_DOWN_DEF2)
                              : (idx == `TLC_IDX_RX_SPARE_DEF1 ||
                              idx == `TLC_IDX_RX_SPARE_DEF2));

         always_ff @(posedge ref_clk)
         begin
            if (srst)
            begin
               rx_def1_reg[gi] <= `TLC_RST_BYTE;
               rx_def2_reg[gi] <= `TLC_RST_BYTE;
            end
            else if (restart[gi])
            begin
               if (idx[0] == 1'b0)
                  rx_def1_reg[gi] <= pwdata[7:0];
               else
                  rx_def2_reg[gi] <= pwdata[7:0];
            end
         end

         // Phase hunt: repeated misses slip the local pattern one bit
         always_ff @(posedge ref_clk)
         begin
            if (srst | restart[gi] | ~t1_mode)
            begin
               phase_reg <= `TLC_RST_PHASE;
               slip_reg <= 4'h0;
            end
            else if (cmp)
            begin
               if (slip)
               begin
                  slip_reg <= 4'h0;
                  phase_reg <= (last == 4'h0) ? `TLC_RST_PHASE : (phase_reg + 4'h2 > last) ?
                               phase_reg + 4'h1 - last : phase_reg + 4'h2;
               end
               else
               begin
                  slip_reg <= miss ? slip_reg + `TLC_SLIP_UP
                                   : (slip_reg != 4'h0 ? slip_reg - 4'h1 : 4'h0);
                  phase_reg <= (phase_reg >= last) ? `TLC_RST_PHASE : phase_reg + 4'h1;
               end
            end
         end

         // Integration window and live status
         always_ff @(posedge ref_clk)
         begin
            if (srst | restart[gi] | ~t1_mode)
            begin
               bit_cnt_reg <= 17'h0_0000;
               err_cnt_reg <= 17'h0_0000;
               live_reg[gi] <= 1'b0;
            end
            else if (win_end[gi])
            begin
               bit_cnt_reg <= 17'h0_0000;
               err_cnt_reg <= 17'h0_0000;
               live_reg[gi] <= (err_cnt_reg + {16'h0000, miss}) <= ERR_LIMIT;
            end
            else if (cmp)
            begin
               bit_cnt_reg <= bit_cnt_reg + 17'h0_0001;
               if (miss && err_cnt_reg != 17'h1_FFFF)
                  err_cnt_reg <= err_cnt_reg + 17'h0_0001;
            end
         end

         always_ff @(posedge ref_clk)
         begin
            if (srst)
               live_d_reg[gi] <= 1'b0;
            else
               live_d_reg[gi] <= live_reg[gi];
         end

         assign live_vec[gi] = live_reg[gi];
         assign rise_vec[gi] = live_reg[gi] & ~live_d_reg[gi];
         assign fall_vec[gi] = ~live_reg[gi] & live_d_reg[gi];
      end
   endgenerate

   // Latched set/clear events; a new event wins over a write-one clear
   logic lat_wr;
   assign lat_wr = wr_en & hit & (idx == `TLC_IDX_RX_LATCHED);

   always_ff @(posedge ref_clk)
   begin
      if (srst)
         latched_reg <= 6'h00;
      else
         latched_reg <= (latched_reg & ~(lat_wr ? pwdata[5:0] : 6'h00))
                        | {fall_vec, rise_vec};
   end

   always_ff @(posedge ref_clk)
   begin
      if (srst)
         loop_irq_pending <= 1'b0;
      else
         loop_irq_pending <= |(latched_reg & rx_irq_mask_reg[5:0]);
   end

   // Checks
   default clocking cb @(posedge ref_clk);
   endclocking
   default disable iff (srst);

   chk_tx_needs_t1: assert property (!t1_mode |=> !tx_loop_active)
      else $error("loop transmit active outside T1 mode");
   chk_tx_enable_follows: assert property (tx_on |=> tx_loop_active)
      else $error("loop transmit not active while enabled");
   chk_tx_fbit_slot: assert property (tx_on && tx_bit_req && tx_fbit_pos && !fbit_off
      |=> tx_loop_data == $past(tx_fbit))
      else $error("framing bit slot not overwritten");
   chk_tx_phase_range: assert property (tx_phase_reg <= tx_last)
      else $error("transmit phase beyond pattern length");
   chk_live_at_window: assert property ($rose(live_reg[0]) |-> $past(win_end[0]))
      else $error("up detect rose outside window end");
   chk_drop_at_window: assert property ($fell(live_reg[1]) |->
      $past(win_end[1] || restart[1] || !t1_mode))
      else $error("down detect fell without cause");
   chk_restart_clears: assert property (restart[0] |=> g_det[0].bit_cnt_reg == 17'h0_0000
      && !live_reg[0])
      else $error("definition write did not restart integration");
   chk_latch_on_rise: assert property ($rose(live_reg[2]) |=> latched_reg[2])
      else $error("spare set event not latched");
   chk_w1c_clear: assert property (lat_wr && pwdata[0] && !rise_vec[0]
      |=> !latched_reg[0])
      else $error("write one did not clear latched bit");
   chk_foreign_framer: assert property (setup &&
      paddr[`TLC_ADDR_FRAMER_HI:`TLC_ADDR_FRAMER_LO] != framer_reg
      |=> pready && pslverr)
      else $error("other framer address not refused");
   chk_irq_gate: assert property (latched_reg[1] && rx_irq_mask_reg[1]
      |=> loop_irq_pending)
      else $error("masked event did not raise pending");

   cov_up_detect: cover property ($rose(live_reg[0]));
   cov_down_drop: cover property ($fell(live_reg[1]));
   cov_tx_loop: cover property (tx_on && tx_bit_req ##1 tx_on && tx_bit_req);
   cov_w1c: cover property (lat_wr && latched_reg != 6'h00);
endmodule

// file: design/tlc_consts.svh
// Constants for the T1 in-band loop code generator and detectors
`ifndef TLC_CONSTS_SVH
`define TLC_CONSTS_SVH

// Register indices for framer zero; byte address is four times the index
`define TLC_IDX_RX_LEN_CTRL 9'h082
`define TLC_IDX_RX_LATCHED 9'h092
`define TLC_IDX_RX_SPARE_DEF1 9'h09C
`define TLC_IDX_RX_SPARE_DEF2 9'h09D
`define TLC_IDX_RX_SPARE_CTRL 9'h09E
`define TLC_IDX_RX_IRQ_MASK 9'h0A2
`define TLC_IDX_RX_UP_DEF1 9'h0AC
`define TLC_IDX_RX_UP_DEF2 9'h0AD
`define TLC_IDX_RX_DOWN_DEF1 9'h0AE
`define TLC_IDX_RX_DOWN_DEF2 9'h0AF
`define TLC_IDX_RX_LIVE 9'h0B2
`define TLC_IDX_TX_CTRL3 9'h183
`define TLC_IDX_TX_CTRL4 9'h186
`define TLC_IDX_TX_DEF1 9'h1AC
`define TLC_IDX_TX_DEF2 9'h1AD

// Address split: framer number above the per-framer index
`define TLC_ADDR_FRAMER_HI 13
`define TLC_ADDR_FRAMER_LO 11
`define TLC_ADDR_IDX_HI 10
`define TLC_ADDR_IDX_LO 2

// Field positions
`define TLC_TX3_LOOP_EN 0
`define TLC_TX3_FBIT_OFF 1
`define TLC_TX4_LEN_HI 1
`define TLC_TX4_LEN_LO 0
`define TLC_LEN_UP_HI 3
`define TLC_LEN_UP_LO 0
`define TLC_LEN_DN_HI 7
`define TLC_LEN_DN_LO 4
`define TLC_LAT_CLR_BASE 3

// Reset values and the last phase of a 16-bit code
`define TLC_RST_BYTE 8'h00
`define TLC_RST_PHASE 4'h0
`define TLC_LAST16 4'hF

// Integration timing
`define TLC_INTEG_MS 48
`define TLC_LINE_RATE_HZ 1544000
`define TLC_INTEG_BITS (`TLC_INTEG_MS * `TLC_LINE_RATE_HZ / 1000)
`define TLC_ERR_DIV 32
`define TLC_SLIP_UP 4'h4
`define TLC_SLIP_LIMIT 4'h8

`endif

// file: design/tlc_pkg.sv
// Types for the T1 in-band loop code block
package tlc_pkg;
   typedef logic [13:0] tlc_addr_t;
   typedef logic [31:0] tlc_data_t;
   typedef logic [3:0] tlc_phase_t;
   typedef enum logic [1:0]
   {
      TLC_TX_LEN5 = 2'b00,
      TLC_TX_LEN6 = 2'b01,
      TLC_TX_LEN7 = 2'b10,
      TLC_TX_LEN16 = 2'b11
   } tlc_tx_len_e;
endpackage

// file: bench/tlc_line_model.sv
// Far-end T1 line model: bit strobes, F-slots and a repeating receive code
module tlc_line_model (
   // Clock and reset
   input wire logic ref_clk,
   input wire logic srst,
   // Bench control
   input wire logic tx_run,
   input wire logic rx_run,
   input wire logic [15:0] rx_code,
   input wire logic [4:0] rx_len,
   // Transmit strobes toward the block
   output logic tx_bit_req,
   output logic tx_fbit_pos,
   output logic tx_fbit,
   // Received line bits
   output logic rx_bit_valid,
   output logic rx_bit,
   output logic rx_fbit_pos
);
   logic [1:0] div_reg;
   logic [7:0] slot_reg;
   logic frame_reg;
   logic [4:0] ph_reg;
   logic [4:0] pos;
   logic stb;
   assign stb = (div_reg == 2'h3);
   assign pos = rx_len - 5'h1 - ph_reg;
   // One line bit every four clocks, 193 bits to a frame
   always_ff @(posedge ref_clk)
   begin
      if (srst)
      begin
         div_reg <= 2'h0;
         slot_reg <= 8'h00;
         frame_reg <= 1'b0;
         ph_reg <= 5'h00;
         tx_bit_req <= 1'b0;
         tx_fbit_pos <= 1'b0;
         tx_fbit <= 1'b0;
         rx_bit_valid <= 1'b0;
         rx_bit <= 1'b0;
         rx_fbit_pos <= 1'b0;
      end
      else
      begin
         div_reg <= div_reg + 2'h1;
         tx_bit_req <= tx_run && stb;
         tx_fbit_pos <= stb && slot_reg == 8'h00;
         rx_bit_valid <= rx_run && stb;
         rx_fbit_pos <= stb && slot_reg == 8'h00;
         if (stb)
         begin
            slot_reg <= (slot_reg == 8'hC0) ? 8'h00 : slot_reg + 8'h01;
            frame_reg <= (slot_reg == 8'hC0) ? ~frame_reg : frame_reg;
            tx_fbit <= frame_reg;
            // Framed code: F-bit inserted, code phase held over the slot
            rx_bit <= (slot_reg == 8'h00) ? frame_reg : rx_code[pos[3:0]];
            if (slot_reg != 8'h00)
               ph_reg <= (ph_reg >= rx_len - 5'h1) ? 5'h00 : ph_reg + 5'h01;
         end
         else
         begin
            // Lines between strobes carry no data
            tx_fbit <= ~tx_fbit;
            rx_bit <= ~rx_bit;
         end
      end
   end
endmodule

// file: bench/testbench.sv
// Self-checking bench for the T1 loop code generator and detectors
`include "tlc_consts.svh"
module testbench;
   timeunit 1ns;
   timeprecision 1ps;
   import tlc_pkg::*;
   logic ref_clk, srst, psel, penable, pwrite, t1_mode, tx_run, rx_run;
   logic [2:0] framer_num;
   tlc_addr_t paddr;
   tlc_data_t pwdata, prdata;
   logic pready, pslverr, tx_bit_req, tx_fbit_pos, tx_fbit, tx_loop_active, tx_loop_data;
   logic rx_bit_valid, rx_bit, rx_fbit_pos, loop_irq_pending, err;
   logic [15:0] rx_code;
   logic [4:0] rx_len;
   logic [7:0] rd;
   int miscompares, comparisons;
   tlc_loop_code #(.INTEG_BITS(200)) u_dut (.ref_clk(ref_clk), .srst(srst), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
      .pready(pready), .pslverr(pslverr), .t1_mode(t1_mode), .framer_num(framer_num),
      .tx_bit_req(tx_bit_req), .tx_fbit_pos(tx_fbit_pos), .tx_fbit(tx_fbit),
      .tx_loop_active(tx_loop_active), .tx_loop_data(tx_loop_data),
      .rx_bit_valid(rx_bit_valid), .rx_bit(rx_bit), .rx_fbit_pos(rx_fbit_pos),
      .loop_irq_pending(loop_irq_pending));
   tlc_line_model u_line (.ref_clk(ref_clk), .srst(srst), .tx_run(tx_run), .rx_run(rx_run),
      .rx_code(rx_code), .rx_len(rx_len), .tx_bit_req(tx_bit_req), .tx_fbit_pos(tx_fbit_pos),
      .tx_fbit(tx_fbit), .rx_bit_valid(rx_bit_valid), .rx_bit(rx_bit),
      .rx_fbit_pos(rx_fbit_pos));
   initial
   begin
      ref_clk = 1'b0;
      forever #20 ref_clk = ~ref_clk;
   end
   task final_report;
      if (miscompares == 0 && comparisons > 0)
         $display("Test passed");
      else
         $display("Test failed");
      $finish;
   endtask
   task chk(input string name, input logic [15:0] exp, input logic [15:0] got);
      comparisons++;
      if (got !== exp)
      begin
         miscompares++;
         $display("BAD %s expected %h seen %h", name, exp, got);
      end
   endtask
   task hang;
      chk("wait", 16'h0000, 16'h0001);
      final_report;
   endtask
   task apb(input logic wr, input logic [8:0] idx, input logic [2:0] fr, input logic [7:0] wd);
      int n;
      @(posedge ref_clk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= wr;
      paddr <= {fr, idx, 2'h0};
      pwdata <= {24'h000000, wd};
      @(posedge ref_clk);
      penable <= 1'b1;
      n = 0;
      do
      begin
         @(posedge ref_clk);
         n++;
      end
      while (pready !== 1'b1 && n < 20);
      if (n >= 20)
         hang;
      rd = prdata[7:0];
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   task wr(input logic [8:0] idx, input logic [7:0] d);
      apb(1'b1, idx, 3'h3, d);
   endtask
   task rdchk(input string name, input logic [8:0] idx, input logic [7:0] exp);
      apb(1'b0, idx, 3'h3, 8'h00);
      chk(name, {8'h00, exp}, {8'h00, rd});
   endtask
   task t_regs;
      logic [8:0] rw [7];
      rw = '{`TLC_IDX_RX_LEN_CTRL, `TLC_IDX_RX_SPARE_DEF1, `TLC_IDX_RX_SPARE_DEF2,
         `TLC_IDX_RX_IRQ_MASK, `TLC_IDX_TX_CTRL4, `TLC_IDX_TX_DEF1, `TLC_IDX_TX_DEF2};
      foreach (rw[i])
      begin
         rdchk("reset value", rw[i], 8'h00);
         wr(rw[i], 8'h5A ^ 8'(i));
         rdchk("read back", rw[i], 8'h5A ^ 8'(i));
      end
      wr(`TLC_IDX_RX_IRQ_MASK, 8'h00);
      wr(`TLC_IDX_RX_LIVE, 8'hFF);
      rdchk("live read only", `TLC_IDX_RX_LIVE, 8'h00);
      apb(1'b0, 9'h000, 3'h3, 8'h00);
      chk("unmapped err", 16'h0001, {15'h0000, err});
      apb(1'b0, `TLC_IDX_TX_DEF1, 3'h2, 8'h00);
      chk("other framer err", 16'h0001, {15'h0000, err});
      apb(1'b0, `TLC_IDX_TX_DEF1, 3'h3, 8'h00);
      chk("own framer err", 16'h0000, {15'h0000, err});
   endtask
   task t_tx(input logic [1:0] lc, input logic [7:0] d1, input logic [7:0] d2, input int nb,
      input logic foff);
      logic [15:0] pat;
      int k;
      int n;
      logic fp;
      logic fv;
      pat = {d1, d2};
      wr(`TLC_IDX_TX_DEF1, d1);
      wr(`TLC_IDX_TX_DEF2, d2);
      wr(`TLC_IDX_TX_CTRL4, {6'h00, lc});
      wr(`TLC_IDX_TX_CTRL3, {6'h00, foff, 1'b1});
      repeat (2) @(posedge ref_clk);
      chk("tx active", 16'h0001, {15'h0000, tx_loop_active});
      tx_run <= 1'b1;
      k = 0;
      n = 0;
      while (k < 400 && n < 4000)
      begin
         @(negedge ref_clk);
         n++;
         if (tx_bit_req === 1'b1)
         begin
            fp = tx_fbit_pos;
            fv = tx_fbit;
            @(negedge ref_clk);
            chk("tx bit", (fp && !foff) ? fv : pat[15 - (k % nb)], tx_loop_data);
            k++;
         end
      end
      if (k < 400)
         hang;
      tx_run <= 1'b0;
      wr(`TLC_IDX_TX_CTRL3, 8'h00);
      repeat (2) @(posedge ref_clk);
      chk("tx stopped", 16'h0000, {15'h0000, tx_loop_active});
   endtask
   task t_rx(input int d, input logic [15:0] code, input logic [4:0] len);
      int n;
      wr(`TLC_IDX_RX_IRQ_MASK, 8'h01 << d);
      rx_code <= code;
      rx_len <= len;
      n = 0;
      while (loop_irq_pending !== 1'b1 && n < 20000)
      begin
         @(posedge ref_clk);
         n++;
      end
      if (n >= 20000)
         hang;
      // Poll until the previous detector has dropped out
      n = 0;
      do
      begin
         apb(1'b0, `TLC_IDX_RX_LIVE, 3'h3, 8'h00);
         n++;
      end
      while (rd !== (8'h01 << d) && n < 1000);
      if (rd !== (8'h01 << d))
         hang;
      rdchk("live", `TLC_IDX_RX_LIVE, 8'h01 << d);
      wr(`TLC_IDX_RX_LATCHED, 8'h00);
      repeat (2) @(posedge ref_clk);
      chk("irq kept", 16'h0001, {15'h0000, loop_irq_pending});
      wr(`TLC_IDX_RX_LATCHED, 8'h01 << d);
      repeat (2) @(posedge ref_clk);
      chk("irq cleared", 16'h0000, {15'h0000, loop_irq_pending});
      wr(`TLC_IDX_RX_IRQ_MASK, 8'h00);
   endtask
   initial
   begin
      srst = 1'b1;
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      paddr = '0;
      pwdata = '0;
      framer_num = 3'h3;
      t1_mode = 1'b1;
      tx_run = 1'b0;
      rx_run = 1'b0;
      rx_code = 16'h0000;
      rx_len = 5'h01;
      miscompares = 0;
      comparisons = 0;
      repeat (8) @(posedge ref_clk);
      srst <= 1'b0;
      t_regs;
      t_tx(2'h0, 8'h80, 8'h00, 5, 1'b0);
      t_tx(2'h2, 8'hD2, 8'hFF, 7, 1'b0);
      t_tx(2'h3, 8'hA5, 8'h3C, 16, 1'b1);
      t1_mode <= 1'b0;
      wr(`TLC_IDX_TX_CTRL3, 8'h01);
      repeat (3) @(posedge ref_clk);
      chk("e1 idle", 16'h0000, {15'h0000, tx_loop_active});
      wr(`TLC_IDX_TX_CTRL3, 8'h00);
      t1_mode <= 1'b1;
      wr(`TLC_IDX_RX_LEN_CTRL, 8'h84);
      wr(`TLC_IDX_RX_UP_DEF1, 8'h80);
      wr(`TLC_IDX_RX_UP_DEF2, 8'hFF);
      wr(`TLC_IDX_RX_DOWN_DEF1, 8'hF0);
      wr(`TLC_IDX_RX_DOWN_DEF2, 8'hA5);
      wr(`TLC_IDX_RX_SPARE_CTRL, 8'h07);
      wr(`TLC_IDX_RX_SPARE_DEF1, 8'h3C);
      wr(`TLC_IDX_RX_SPARE_DEF2, 8'h3C);
      wr(`TLC_IDX_RX_LATCHED, 8'h3F);
      rx_run <= 1'b1;
      t_rx(0, 16'h0010, 5'h05);
      t_rx(1, 16'hF0A5, 5'h10);
      t_rx(2, 16'h003C, 5'h08);
      wr(`TLC_IDX_RX_SPARE_DEF1, 8'h3C);
      rdchk("restart live", `TLC_IDX_RX_LIVE, 8'h00);
      apb(1'b0, `TLC_IDX_RX_LATCHED, 3'h3, 8'h00);
      chk("clear event", 16'h0020, {8'h00, rd & 8'h20});
      final_report;
   end
endmodule
